//--- ppr_router.sv
// Overview of operation
// (R1) many inputs may share one pin
// (R2) port read returns true pin level
// (R3) software clears analog select before routing
// (R4) one common port/pin input encoding
// (R5) one common output source encoding
// (R6) direction bit controls driver normally
// (R7) uart and i2c override direction bit
// (R8) bidirectional signals use same pin
// (R9) lock blocks all selector writes
// (R10) lock change needs 55h then AAh
// (R11) bit-0 change right after second key
// (R12) one-shot mode: one clear, one set
// (R13) one-shot relock sticks until reset
// (R14) sleep leaves selections unchanged
// (R15) power-on restores defaults, others keep
// (R16) any reset releases one-shot lock; here only i_nrst releases it, i_npor alone does not
// (R17) input bits 7:5 zero, 4:3 port
// (R18) input bits 2:0 pin number
// (R19) input reset values encode default pins
// (R20) software avoids unavailable ports
// (R21) output zero selects port latch
// (R22) broken key sequence restarts, no change
//
// Chosen here: the APB interface to the registers and the placing of the registers.
module ppr_router
  import ppr_pkg::*;
(
  // clock and resets
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  input  wire logic        i_npor,
  // mode and power
  input  wire logic        i_one_shot_lock_config,
  input  wire logic        i_sleep,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // status
  output logic             o_route_lock_bit,
  // link to peripherals and pins
  ppr_if.router            link
);
  logic [4:0]  in_sel_reg  [PPR_NUM_IN];
  logic [5:0]  out_sel_reg [PPR_NUM_PIN];
  logic [23:0] dir_reg;
  logic [23:0] lat_reg;
  logic [23:0] ana_reg;
  logic        lock_reg;
  logic        used_clear_reg;
  logic        stuck_reg;
  ppr_key_t    key_reg;
  logic [19:0] in_lvl;
  logic [23:0] dig_pins;
  logic        wr;
  logic        rd;
  logic        sel_wr_ok;
  logic        lock_wr;
  logic [7:0]  wb;
  logic [7:0]  in_idx;
  logic [7:0]  out_idx;
  logic        is_in;
  logic        is_out;
  logic        mapped;

  assign wr      = i_psel && i_penable && i_pwrite && o_pready;
  assign rd      = i_psel && !i_pwrite && !i_penable;
  assign wb      = i_pwdata[7:0];
  assign in_idx  = 8'((i_paddr - PPR_IN_BASE) >> 2);
  assign out_idx = 8'((i_paddr - PPR_OUT_BASE) >> 2);
  assign is_in   = (i_paddr < PPR_IN_BASE + 12'(PPR_NUM_IN * 4)) && (i_paddr[1:0] == 2'h0);
  assign is_out  = (i_paddr >= PPR_OUT_BASE) && (i_paddr < PPR_OUT_BASE + 12'(PPR_NUM_PIN * 4))
                   && (i_paddr[1:0] == 2'h0);
  assign mapped  = is_in || is_out || i_paddr == PPR_LOCK_ADDR || i_paddr == PPR_CFG_ADDR
                   || i_paddr == PPR_PORT_ADDR || i_paddr == PPR_DIR_ADDR
                   || i_paddr == PPR_LAT_ADDR || i_paddr == PPR_ANA_ADDR;
  // sleep does not gate writes or state; selections simply hold (see R14)
  assign sel_wr_ok = wr && !lock_reg; // see R9
  assign lock_wr   = wr && i_paddr == PPR_LOCK_ADDR;

  // analog pins feed no digital level (see R3)
  assign dig_pins = link.pin_level & ~ana_reg;

  genvar g;
  generate
    for (g = 0; g < PPR_NUM_IN; g++)
    begin : g_in
      ppr_in_mux u_mux
      (
        .i_sel   (in_sel_reg[g]),
        .i_pins  (dig_pins),
        .o_level (in_lvl[g])
      );
    end
  endgenerate

  always_ff @(posedge i_clk_sys)
  begin
    link.periph_in <= in_lvl; // see R1
  end

  // output routing: code 0 is the latch, uart/i2c own the driver
  always_ff @(posedge i_clk_sys)
  begin
    for (int p = 0; p < PPR_NUM_PIN; p++)
    begin
      if (out_sel_reg[p] == PPR_SRC_LATCH)
        link.pin_out[p] <= lat_reg[p]; // see R21
      else
        link.pin_out[p] <= link.periph_out[out_sel_reg[p]]; // see R5
      if ((out_sel_reg[p] >= PPR_SRC_UART_LO && out_sel_reg[p] <= PPR_SRC_UART_HI)
          || (out_sel_reg[p] >= PPR_SRC_I2C_LO && out_sel_reg[p] <= PPR_SRC_I2C_HI))
        link.pin_oe[p] <= link.periph_oe[out_sel_reg[p]]; // see R7
      else
        link.pin_oe[p] <= dir_reg[p]; // see R6
    end
  end

  // selectors only answer to power-on reset (see R15)
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_npor)
    begin
      for (int k = 0; k < PPR_NUM_IN; k++)
        in_sel_reg[k] <= PPR_IN_RESET[k]; // see R19
      for (int k = 0; k < PPR_NUM_PIN; k++)
        out_sel_reg[k] <= PPR_SRC_LATCH;
    end
    else if (sel_wr_ok)
    begin
      if (is_in)
        in_sel_reg[5'(in_idx)] <= wb[4:0]; // see R4 see R17
      if (is_out)
        out_sel_reg[5'(out_idx)] <= wb[5:0];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      // holds driver enables: all pins start as inputs, no driver on (see R6)
      dir_reg <= 24'h00_0000;
      lat_reg <= 24'h00_0000;
      ana_reg <= 24'hff_ffff;
    end
    else if (wr)
    begin
      if (i_paddr == PPR_DIR_ADDR)
        dir_reg <= ~i_pwdata[23:0];
      if (i_paddr == PPR_LAT_ADDR)
        lat_reg <= i_pwdata[23:0];
      if (i_paddr == PPR_ANA_ADDR)
        ana_reg <= i_pwdata[23:0];
    end
  end

  // key sequence: any other lock-register write restarts it
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
      key_reg <= PPR_KEY_IDLE;
    else if (lock_wr)
    begin
      case (key_reg)
        PPR_KEY_IDLE: key_reg <= (wb == PPR_KEY1) ? PPR_KEY_GOT1 : PPR_KEY_IDLE; // see R10
        PPR_KEY_GOT1: key_reg <= (wb == PPR_KEY2) ? PPR_KEY_OPEN : PPR_KEY_IDLE;
        PPR_KEY_OPEN: key_reg <= (wb == PPR_KEY1) ? PPR_KEY_GOT1 : PPR_KEY_IDLE; // see R22
        default:      key_reg <= PPR_KEY_IDLE;
      endcase
    end
  end

  // lock bit survives non-power-on resets like the selections it guards
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_npor)
      lock_reg <= 1'b0;
    else if (lock_wr && key_reg == PPR_KEY_OPEN && !stuck_reg) // see R11
    begin
      if (!(i_one_shot_lock_config && used_clear_reg && !wb[PPR_LOCK_BIT]))
        lock_reg <= wb[PPR_LOCK_BIT];
    end
  end

  // one-shot tracking, released by the i_nrst reset only (power-on reset alone on i_npor leaves it)
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      used_clear_reg <= 1'b0; // see R16
      stuck_reg      <= 1'b0;
    end
    else if (lock_wr && key_reg == PPR_KEY_OPEN && i_one_shot_lock_config && !stuck_reg)
    begin
      if (!wb[PPR_LOCK_BIT])
        used_clear_reg <= 1'b1; // see R12
      else if (used_clear_reg)
        stuck_reg <= 1'b1; // see R13
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      if (rd)
      begin
        o_prdata <= 32'h0000_0000;
        if (is_in)
          o_prdata <= {27'h000_0000, in_sel_reg[5'(in_idx)]};
        else if (is_out)
          o_prdata <= {26'h000_0000, out_sel_reg[5'(out_idx)]};
        else if (i_paddr == PPR_LOCK_ADDR)
          o_prdata <= {31'h0000_0000, lock_reg};
        else if (i_paddr == PPR_CFG_ADDR)
          o_prdata <= {30'h0000_0000, stuck_reg, used_clear_reg};
        else if (i_paddr == PPR_PORT_ADDR)
          o_prdata <= {8'h00, link.pin_level}; // see R2
        else if (i_paddr == PPR_DIR_ADDR)
          o_prdata <= {8'h00, ~dir_reg};
        else if (i_paddr == PPR_LAT_ADDR)
          o_prdata <= {8'h00, lat_reg};
        else if (i_paddr == PPR_ANA_ADDR)
          o_prdata <= {8'h00, ana_reg};
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    o_route_lock_bit <= lock_reg;
  end
endmodule

//--- ppr_pkg.sv
package ppr_pkg;
  // register byte address map (array entries at base + index * 4)
  localparam int  PPR_NUM_IN      = 20;
  localparam int  PPR_NUM_PIN     = 24;
  localparam int  PPR_NUM_PERIPH  = 64;
  localparam logic [11:0] PPR_IN_BASE   = 12'h000;
  localparam logic [11:0] PPR_OUT_BASE  = 12'h080;
  localparam logic [11:0] PPR_LOCK_ADDR = 12'h100;
  localparam logic [11:0] PPR_CFG_ADDR  = 12'h104;
  localparam logic [11:0] PPR_PORT_ADDR = 12'h108;
  localparam logic [11:0] PPR_DIR_ADDR  = 12'h10c;
  localparam logic [11:0] PPR_LAT_ADDR  = 12'h110;
  localparam logic [11:0] PPR_ANA_ADDR  = 12'h114;
  // selector fields
  localparam int  PPR_IN_PORT_MSB = 4;
  localparam int  PPR_IN_PORT_LSB = 3;
  localparam int  PPR_IN_PIN_MSB  = 2;
  localparam logic [1:0] PPR_PORT_RSVD = 2'h3;
  localparam logic [5:0] PPR_SRC_LATCH = 6'h00;
  localparam int  PPR_LOCK_BIT    = 0;
  localparam logic [7:0] PPR_KEY1 = 8'h55;
  localparam logic [7:0] PPR_KEY2 = 8'hAA;
  // output codes of peripherals that own the driver
  localparam logic [5:0] PPR_SRC_UART_LO = 6'h13;
  localparam logic [5:0] PPR_SRC_UART_HI = 6'h18;
  localparam logic [5:0] PPR_SRC_I2C_LO  = 6'h21;
  localparam logic [5:0] PPR_SRC_I2C_HI  = 6'h24;
  localparam logic [4:0] PPR_IN_RESET [PPR_NUM_IN] = '{
    5'h08, 5'h09, 5'h0a, 5'h04, 5'h10, 5'h0d, 5'h10, 5'h10, 5'h12, 5'h0c,
    5'h13, 5'h15, 5'h0f, 5'h12, 5'h11, 5'h0d, 5'h08, 5'h10, 5'h11, 5'h08};
  typedef enum logic [1:0] {PPR_KEY_IDLE, PPR_KEY_GOT1, PPR_KEY_OPEN} ppr_key_t;
endpackage

//--- ppr_if.sv
interface ppr_if;
  import ppr_pkg::*;
  logic [23:0] pin_level;
  logic [23:0] pin_out;
  logic [23:0] pin_oe;
  logic [19:0] periph_in;
  logic [63:0] periph_out;
  logic [63:0] periph_oe;
  modport router (input pin_level, input periph_out, input periph_oe,
                  output pin_out, output pin_oe, output periph_in);
  modport periph (output pin_level, output periph_out, output periph_oe,
                  input pin_out, input pin_oe, input periph_in);
endinterface

//--- ppr_in_mux.sv
module ppr_in_mux
  import ppr_pkg::*;
(
  // selector and pins
  input  wire logic [4:0]  i_sel,
  input  wire logic [23:0] i_pins,
  // selected level
  output logic             o_level
);
  // reserved port reads low; every input may name any pin at once (see R1)
  always_comb
  begin
    if (i_sel[PPR_IN_PORT_MSB:PPR_IN_PORT_LSB] == PPR_PORT_RSVD)
      o_level = 1'b0;
    else
      o_level = i_pins[i_sel]; // see R4 see R18
  end
endmodule

//--- ppr_periph.sv
// peripheral side: registers pins and peripheral outputs onto the link
module ppr_periph
  import ppr_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // user side
  input  wire logic [23:0] i_pin_level,
  input  wire logic [63:0] i_periph_out,
  input  wire logic [63:0] i_periph_oe,
  output logic [19:0]      o_periph_in,
  output logic [23:0]      o_pin_out,
  output logic [23:0]      o_pin_oe,
  // link
  ppr_if.periph            link
);
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      link.pin_level  <= 24'h00_0000;
      link.periph_out <= 64'h0000_0000_0000_0000;
      link.periph_oe  <= 64'h0000_0000_0000_0000;
      o_periph_in     <= 20'h0_0000;
      o_pin_out       <= 24'h00_0000;
      o_pin_oe        <= 24'h00_0000;
    end
    else
    begin
      link.pin_level  <= i_pin_level;
      // an i2c or capture line must use one pin both ways (see R8)
      link.periph_out <= i_periph_out;
      link.periph_oe  <= i_periph_oe;
      o_periph_in     <= link.periph_in;
      o_pin_out       <= link.pin_out;
      o_pin_oe        <= link.pin_oe;
    end
  end
endmodule

//--- ppr_props.sv
module ppr_props
  import ppr_pkg::*;
(
  // clock, resets, mode
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_npor,
  input wire logic        i_sleep,
  // apb side
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_route_lock_bit,
  // link
  input wire logic [23:0] pin_out,
  input wire logic [19:0] periph_in
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire logic rd_ok = i_psel && i_penable && !i_pwrite && o_pready;
  wire logic lk_wr = i_psel && i_penable && i_pwrite && o_pready && i_paddr == PPR_LOCK_ADDR;
  logic [1:0] nrst_hist;
  logic [1:0] npor_hist;
  // reset history kept in flops; lock checks skip cycles near any reset
  always_ff @(posedge i_clk_sys)
  begin
    nrst_hist <= {nrst_hist[0], i_nrst};
    npor_hist <= {npor_hist[0], i_npor};
  end
  // lock output trails the lock register by one cycle
  wire logic quiet = nrst_hist[0] && nrst_hist[1] && i_npor && npor_hist[0] && npor_hist[1];
  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  ready_access_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access");
  err_pair_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  err_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  in_sel_bits_a: assert property (rd_ok && i_paddr < PPR_OUT_BASE |-> o_prdata[31:5] == 27'h000_0000)
    else $error("input selector upper bits set");
  lock_cause_a: assert property ($changed(o_route_lock_bit) && quiet |-> $past(lk_wr, 2))
    else $error("lock changed without lock write");
  lock_value_a: assert property ($changed(o_route_lock_bit) && quiet |-> o_route_lock_bit == $past(i_pwdata[0], 2))
    else $error("lock took wrong value");
  sleep_hold_a: assert property ($changed(i_sleep) |=> $stable(pin_out) && $stable(periph_in))
    else $error("routing moved with sleep");
endmodule

//--- peripheral_pin_router_tb_top.sv
module peripheral_pin_router_tb_top
  import ppr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] CRN [10] = '{6'h00, 6'h12, 6'h13, 6'h18, 6'h19, 6'h20, 6'h21, 6'h24, 6'h25, 6'h3f};
  logic        i_clk_sys = 0, i_nrst = 0, i_npor = 0, i_one_shot_lock_config = 0, i_sleep = 0;
  logic        i_psel = 0, i_penable = 0, i_pwrite = 0, o_pready, o_pslverr, o_route_lock_bit, err;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000, o_prdata, rd;
  logic [23:0] i_pin_level = 24'h00_0000, o_pin_out, o_pin_oe, lat, dir;
  logic [63:0] i_periph_out = 64'h0, i_periph_oe = 64'h0;
  logic [19:0] o_periph_in;
  logic [4:0]  isel [PPR_NUM_IN];
  logic [5:0]  osel [PPR_NUM_PIN];
  int          bad_count = 0, n_tests = 0, cyc = 0;
  ppr_if link ();
  ppr_router u_ppr_router (.i_clk_sys, .i_nrst, .i_npor, .i_one_shot_lock_config, .i_sleep, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_route_lock_bit,
    .link(link.router));
  ppr_periph u_ppr_periph (.i_clk_sys, .i_nrst, .i_pin_level, .i_periph_out, .i_periph_oe, .o_periph_in,
    .o_pin_out, .o_pin_oe, .link(link.periph));
  ppr_props u_ppr_props (.i_clk_sys, .i_nrst, .i_npor, .i_sleep, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_route_lock_bit, .pin_out(link.pin_out),
    .periph_in(link.periph_in));
  always #50 i_clk_sys = ~i_clk_sys;
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // entered just after a rising edge, leaves just after one
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    do
      @(posedge i_clk_sys);
    while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk_sys);
  endtask
  task automatic lk(input logic [7:0] k1, input logic [7:0] k2, input logic b, input logic exp);
    apb(1'h1, PPR_LOCK_ADDR, {24'h00_0000, k1});
    apb(1'h1, PPR_LOCK_ADDR, {24'h00_0000, k2});
    apb(1'h1, PPR_LOCK_ADDR, {31'h0, b});
    apb(1'h0, PPR_LOCK_ADDR, 32'h0);
    chk("lock", rd[PPR_LOCK_BIT], exp);
    chk("lock_pin", o_route_lock_bit, exp);
  endtask
  function automatic logic exp_in(logic [4:0] s, logic [23:0] p);
    return (s[4:3] == PPR_PORT_RSVD) ? 1'h0 : p[s];
  endfunction
  function automatic logic [1:0] exp_pin(logic [5:0] c, logic l, logic d, logic o, logic e);
    logic ov;
    ov = (c >= PPR_SRC_UART_LO && c <= PPR_SRC_UART_HI) || (c >= PPR_SRC_I2C_LO && c <= PPR_SRC_I2C_HI);
    return {(c == PPR_SRC_LATCH) ? l : o, ov ? e : ~d};
  endfunction
  task automatic rst(input logic por);
    i_nrst <= 1'h0;
    i_npor <= ~por;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    i_npor <= 1'h1;
    @(posedge i_clk_sys);
    apb(1'h0, PPR_IN_BASE, 32'h0);
    chk("sel_after_reset", rd, {27'h0, por ? PPR_IN_RESET[0] : isel[0]});
  endtask
  initial
  begin
    void'($urandom(32'hc105));
    repeat (8) @(posedge i_clk_sys);
    i_nrst <= 1'h1;
    i_npor <= 1'h1;
    @(posedge i_clk_sys);
    for (int i = 0; i < PPR_NUM_IN; i++)
    begin
      apb(1'h0, PPR_IN_BASE + 12'(4 * i), 32'h0);
      chk("in_reset", rd, {27'h0, PPR_IN_RESET[i]});
    end
    for (int p = 0; p < PPR_NUM_PIN; p++)
    begin
      apb(1'h0, PPR_OUT_BASE + 12'(4 * p), 32'h0);
      chk("out_reset", rd, 32'h0);
    end
    chk("oe_reset", {8'h00, o_pin_oe}, 32'h0000_0000);
    apb(1'h0, 12'h200, 32'h0);
    chk("unmapped_err", err, 1'h1);
    chk("unmapped_rd", rd, 32'h0000_0000);
    apb(1'h1, PPR_ANA_ADDR, 32'h0);
    repeat (4)
    begin
      for (int i = 0; i < PPR_NUM_IN; i++)
      begin
        isel[i] = (i < 3) ? 5'h0c : 5'($urandom);
        apb(1'h1, PPR_IN_BASE + 12'(4 * i), {24'h0, 3'h7, isel[i]});
      end
      for (int p = 0; p < PPR_NUM_PIN; p++)
      begin
        osel[p] = (p < 10) ? CRN[p] : (p == 12) ? PPR_SRC_I2C_LO : 6'($urandom);
        apb(1'h1, PPR_OUT_BASE + 12'(4 * p), {26'h0, osel[p]});
      end
      dir = 24'($urandom);
      lat = 24'($urandom);
      apb(1'h1, PPR_DIR_ADDR, {8'h00, dir});
      apb(1'h1, PPR_LAT_ADDR, {8'h00, lat});
      i_pin_level <= 24'($urandom);
      i_periph_out <= {$urandom, $urandom};
      i_periph_oe <= {$urandom, $urandom};
      repeat (4) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      for (int i = 0; i < PPR_NUM_IN; i++)
        chk("periph_in", o_periph_in[i], exp_in(isel[i], i_pin_level));
      for (int p = 0; p < PPR_NUM_PIN; p++)
        chk("pin", {o_pin_out[p], o_pin_oe[p]}, exp_pin(osel[p], lat[p], dir[p], i_periph_out[osel[p]],
          i_periph_oe[osel[p]]));
      @(posedge i_clk_sys);
      apb(1'h0, PPR_PORT_ADDR, 32'h0);
      chk("port", rd, {8'h00, i_pin_level});
      apb(1'h0, PPR_IN_BASE + 12'h00c, 32'h0);
      chk("in_readback", rd, {27'h0, isel[3]});
    end
    lk(PPR_KEY1, PPR_KEY2, 1'h1, 1'h1);
    apb(1'h1, PPR_IN_BASE, 32'h0000_0003);
    apb(1'h1, PPR_OUT_BASE + 12'h004, 32'h0000_0001);
    apb(1'h0, PPR_IN_BASE, 32'h0);
    chk("locked_in", rd, {27'h0, isel[0]});
    apb(1'h0, PPR_OUT_BASE + 12'h004, 32'h0);
    chk("locked_out", rd, {26'h0, osel[1]});
    apb(1'h1, PPR_LOCK_ADDR, {24'h00_0000, PPR_KEY1});
    lk(8'h12, PPR_KEY2, 1'h0, 1'h1);
    lk(PPR_KEY1, PPR_KEY2, 1'h0, 1'h0);
    i_one_shot_lock_config <= 1'h1;
    lk(PPR_KEY1, PPR_KEY2, 1'h1, 1'h1);
    // one clear and one set allowed, then the lock sticks
    lk(PPR_KEY1, PPR_KEY2, 1'h0, 1'h0);
    lk(PPR_KEY1, PPR_KEY2, 1'h1, 1'h1);
    lk(PPR_KEY1, PPR_KEY2, 1'h0, 1'h1);
    // warm reset keeps selections and the lock but frees the one-shot
    rst(1'h0);
    lk(PPR_KEY1, PPR_KEY2, 1'h0, 1'h0);
    i_sleep <= 1'h1;
    repeat (3) @(posedge i_clk_sys);
    i_sleep <= 1'h0;
    @(posedge i_clk_sys);
    apb(1'h0, PPR_IN_BASE, 32'h0);
    chk("sleep_sel", rd, {27'h0, isel[0]});
    rst(1'h1);
    end_of_test();
  end
endmodule
